/* src/bmp_pkg.sv */
package bmp_pkg;

   // ==========================================================
   // Data widths and register map.
   localparam int POS_W = 32;
   localparam int ADR_W = 6;
   localparam int BLK_DEPTH = 16;
   localparam int BLK_IDX_W = 4;

   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_BACKLASH = 6'h04;
   localparam logic [5:0] REG_MOD_RANGE = 6'h08;
   localparam logic [5:0] REG_SW_LIM_NEG = 6'h0C;
   localparam logic [5:0] REG_SW_LIM_POS = 6'h10;
   localparam logic [5:0] REG_CORR = 6'h14;
   localparam logic [5:0] REG_MOD_OFFS = 6'h18;
   localparam logic [5:0] REG_STATUS = 6'h1C;
   localparam logic [5:0] REG_BLK_SEL = 6'h20;
   localparam logic [5:0] REG_BLK_HDR = 6'h24;
   localparam logic [5:0] REG_BLK_TGT = 6'h28;
   localparam logic [5:0] REG_BLK_PAR = 6'h2C;
   localparam logic [5:0] REG_SETPOINT = 6'h30;

   // ==========================================================
   // Control register fields.
   localparam int CTRL_MODULE_EN = 0;
   localparam int CTRL_MOD_OFFS_EN = 1;
   localparam int CTRL_ABS_ENC = 2;
   localparam int CTRL_HOME_DIR = 3;
   localparam int CTRL_SW_LIM_EN = 4;
   localparam int CTRL_SETUP_MODE = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Status register fields.
   localparam int ST_MODULE_ACTIVE = 0;
   localparam int ST_CORR_ACTIVE = 1;
   localparam int ST_APPLY = 2;
   localparam int ST_LIMITED = 3;
   localparam int ST_DIR_POS = 4;

   // Traversing block header fields.
   localparam int BH_JOB_LSB = 0;
   localparam int BH_TASK_LSB = 8;
   localparam int BH_MODE_LSB = 12;
   localparam int BH_VEL_LSB = 16;
   localparam int BH_ACC_LSB = 24;

   localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0] {
      BMP_DIR_STILL = 2'b00,
      BMP_DIR_POS = 2'b01,
      BMP_DIR_NEG = 2'b11
   } bmp_dir_t;

   typedef enum logic [1:0] {
      BMP_ST_IDLE = 2'b00,
      BMP_ST_WAIT = 2'b01,
      BMP_ST_ACTIVE = 2'b11
   } bmp_state_t;

endpackage

/* src/bmp_modulo_wrap.sv */
`timescale 1ns/10ps
module bmp_modulo_wrap
   import bmp_pkg::*;
#(
   parameter int WIDTH = POS_W
) (
   input wire logic signed [WIDTH-1:0] position,
   input wire logic signed [WIDTH-1:0] modulo_range,
   output logic signed [WIDTH-1:0] wrapped,
   output logic signed [WIDTH-1:0] wrap_step
);

   initial begin
      if (WIDTH < 8) begin
         $error("bmp_modulo_wrap: WIDTH too small");
      end
   end

   // One range step per sample: the setpoint moves far less than a
   // full range in one cycle, so a single fold keeps it in range.
   always_comb begin
      wrapped = position;
      wrap_step = '0;
      if (modulo_range > 0) begin
         if (position >= modulo_range) begin
            wrapped = position - modulo_range;
            wrap_step = -modulo_range;
         end else if (position < 0) begin
            wrapped = position + modulo_range;
            wrap_step = modulo_range;
         end
      end
   end

endmodule // bmp_modulo_wrap

/* src/bmp_positioner.sv */
`timescale 1ns/10ps
module bmp_positioner
   import bmp_pkg::*;
#(
   parameter int DEPTH = BLK_DEPTH
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic position_control_active,
   input wire logic axis_referenced,
   input wire logic axis_adjusted,
   input wire logic signed [POS_W-1:0] setpoint_step,
   output logic positioner_module_active,
   output logic signed [POS_W-1:0] position_setpoint,
   output logic signed [POS_W-1:0] position_offset_input,
   output logic signed [POS_W-1:0] modulo_offset_value,
   output logic offset_apply_strobe
);

   initial begin
      if (DEPTH != (1 << BLK_IDX_W)) begin
         $error("bmp_positioner: DEPTH must match block index width");
      end
   end

   // ==========================================================
   // Register bus slave
   logic [31:0] ctrl;
   logic signed [POS_W-1:0] backlash_amount;
   logic signed [POS_W-1:0] modulo_range;
   logic signed [POS_W-1:0] sw_lim_neg;
   logic signed [POS_W-1:0] sw_lim_pos;
   logic signed [POS_W-1:0] direct_setpoint;
   logic [BLK_IDX_W-1:0] blk_sel;
   logic [31:0] blk_hdr [DEPTH];
   logic [31:0] blk_tgt [DEPTH];
   logic [31:0] blk_par [DEPTH];
   logic signed [POS_W-1:0] backlash_correction_value;
   logic [31:0] status;
   logic bus_req;
   logic bus_wr;
   logic [31:0] next_rdata;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   // One wait state: ack follows the request by one edge and drops
   // in the next, so back-to-back cycles are never double counted.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         backlash_amount <= '0;
         modulo_range <= '0;
         sw_lim_neg <= '0;
         sw_lim_pos <= '0;
         direct_setpoint <= '0;
         blk_sel <= '0;
      end else if (bus_wr) begin
         case (wb_adr_i)
            REG_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
            REG_BACKLASH: backlash_amount <=
               merge(backlash_amount, wb_dat_i, wb_sel_i);
            REG_MOD_RANGE: modulo_range <=
               merge(modulo_range, wb_dat_i, wb_sel_i);
            REG_SW_LIM_NEG: sw_lim_neg <=
               merge(sw_lim_neg, wb_dat_i, wb_sel_i);
            REG_SW_LIM_POS: sw_lim_pos <=
               merge(sw_lim_pos, wb_dat_i, wb_sel_i);
            REG_SETPOINT: direct_setpoint <=
               merge(direct_setpoint, wb_dat_i, wb_sel_i);
            REG_BLK_SEL: begin
               if (wb_sel_i[0]) begin
                  blk_sel <= wb_dat_i[BLK_IDX_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Block store: job, task, mode and overrides in the header word,
   // target position and job parameters in two more words.
   always_ff @(posedge clock) begin
      if (bus_wr && wb_adr_i == REG_BLK_HDR) begin
         blk_hdr[blk_sel] <= merge(blk_hdr[blk_sel], wb_dat_i,
                                   wb_sel_i);
      end
      if (bus_wr && wb_adr_i == REG_BLK_TGT) begin
         blk_tgt[blk_sel] <= merge(blk_tgt[blk_sel], wb_dat_i,
                                   wb_sel_i);
      end
      if (bus_wr && wb_adr_i == REG_BLK_PAR) begin
         blk_par[blk_sel] <= merge(blk_par[blk_sel], wb_dat_i,
                                   wb_sel_i);
      end
   end

   always_comb begin
      case (wb_adr_i)
         REG_CTRL: next_rdata = ctrl;
         REG_BACKLASH: next_rdata = backlash_amount;
         REG_MOD_RANGE: next_rdata = modulo_range;
         REG_SW_LIM_NEG: next_rdata = sw_lim_neg;
         REG_SW_LIM_POS: next_rdata = sw_lim_pos;
         REG_CORR: next_rdata = backlash_correction_value;
         REG_MOD_OFFS: next_rdata = modulo_offset_value;
         REG_STATUS: next_rdata = status;
         REG_BLK_SEL: next_rdata = {28'h0000000, blk_sel};
         REG_BLK_HDR: next_rdata = blk_hdr[blk_sel];
         REG_BLK_TGT: next_rdata = blk_tgt[blk_sel];
         REG_BLK_PAR: next_rdata = blk_par[blk_sel];
         REG_SETPOINT: next_rdata = direct_setpoint;
         default: next_rdata = BUS_UNMAPPED;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_dat_o <= '0;
      end else if (bus_req) begin
         wb_dat_o <= next_rdata;
      end
   end

   // ==========================================================
   // Module activation
   logic module_en;
   logic mod_en;
   logic abs_enc;
   logic home_dir;
   bmp_state_t state;
   bmp_state_t next_state;

   assign module_en = ctrl[CTRL_MODULE_EN];
   assign mod_en = ctrl[CTRL_MOD_OFFS_EN];
   assign abs_enc = ctrl[CTRL_ABS_ENC];
   assign home_dir = ctrl[CTRL_HOME_DIR];

   // The module waits for position control and drops out one edge
   // after position control goes away.
   always_comb begin
      case (state)
         BMP_ST_IDLE: next_state = module_en ? BMP_ST_WAIT : BMP_ST_IDLE;
         BMP_ST_WAIT: begin
            if (!module_en) begin
               next_state = BMP_ST_IDLE;
            end else if (position_control_active) begin
               next_state = BMP_ST_ACTIVE;
            end else begin
               next_state = BMP_ST_WAIT;
            end
         end
         BMP_ST_ACTIVE: begin
            if (!module_en) begin
               next_state = BMP_ST_IDLE;
            end else if (!position_control_active) begin
               next_state = BMP_ST_WAIT;
            end else begin
               next_state = BMP_ST_ACTIVE;
            end
         end
         default: next_state = BMP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= BMP_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign positioner_module_active = (state == BMP_ST_ACTIVE);

   // ==========================================================
   // Setpoint path with modulo wrap and software limits
   logic signed [POS_W-1:0] raw_setpoint;
   logic signed [POS_W-1:0] wrapped;
   logic signed [POS_W-1:0] wrap_step;
   logic signed [POS_W-1:0] limited;
   logic lim_hit;
   bmp_dir_t dir;

   assign raw_setpoint = position_setpoint + setpoint_step;

   bmp_modulo_wrap #(.WIDTH(POS_W)) u_wrap (
      .position(raw_setpoint),
      .modulo_range(modulo_range),
      .wrapped(wrapped),
      .wrap_step(wrap_step)
   );

   // Limits are meaningless on an endless axis, so they are bypassed
   // whenever the modulo offset is enabled.
   always_comb begin
      limited = raw_setpoint;
      lim_hit = 1'b0;
      if (ctrl[CTRL_SW_LIM_EN] && !mod_en && axis_referenced) begin
         if (raw_setpoint > sw_lim_pos) begin
            limited = sw_lim_pos;
            lim_hit = 1'b1;
         end else if (raw_setpoint < sw_lim_neg) begin
            limited = sw_lim_neg;
            lim_hit = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         position_setpoint <= '0;
      end else if (!positioner_module_active) begin
         position_setpoint <= position_setpoint;
      end else if (bus_wr && wb_adr_i == REG_SETPOINT) begin
         // Take the word being written, not the register's old value.
         position_setpoint <= merge(direct_setpoint, wb_dat_i,
                                    wb_sel_i);
      end else if (mod_en) begin
         position_setpoint <= wrapped;
      end else begin
         position_setpoint <= limited;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         modulo_offset_value <= '0;
         offset_apply_strobe <= 1'b0;
      end else begin
         offset_apply_strobe <= 1'b0;
         if (positioner_module_active && mod_en && wrap_step != 0) begin
            modulo_offset_value <= wrap_step;
            offset_apply_strobe <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Backlash correction
   logic corr_allowed;
   logic corr_allowed_d;
   bmp_dir_t last_dir;

   always_comb begin
      if (setpoint_step > 0) begin
         dir = BMP_DIR_POS;
      end else if (setpoint_step < 0) begin
         dir = BMP_DIR_NEG;
      end else begin
         dir = BMP_DIR_STILL;
      end
   end

   assign corr_allowed = positioner_module_active &&
                         (abs_enc ? axis_adjusted : axis_referenced);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         corr_allowed_d <= 1'b0;
         last_dir <= BMP_DIR_STILL;
         backlash_correction_value <= '0;
      end else begin
         corr_allowed_d <= corr_allowed;
         if (!corr_allowed) begin
            backlash_correction_value <= '0;
            last_dir <= BMP_DIR_STILL;
         end else if (!corr_allowed_d) begin
            // Seed the far side, so that the first move in the start
            // direction counts as a reversal and applies at once.
            last_dir <= home_dir ? BMP_DIR_NEG : BMP_DIR_POS;
         end else if (dir != BMP_DIR_STILL && dir != last_dir) begin
            last_dir <= dir;
            if (dir == (home_dir ? BMP_DIR_POS : BMP_DIR_NEG)) begin
               backlash_correction_value <= backlash_amount;
            end else begin
               backlash_correction_value <= '0;
            end
         end
      end
   end

   assign position_offset_input = backlash_correction_value;

   assign status = {27'h0000000, (dir == BMP_DIR_POS), lim_hit,
                    offset_apply_strobe, (backlash_correction_value != 0),
                    positioner_module_active};

endmodule // bmp_positioner

/* verification/bmp_checker.sv */
`timescale 1ns/10ps
// ==========================================================
// Port-level checker for the positioner.
module bmp_checker
   import bmp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic position_control_active,
   input wire logic axis_referenced,
   input wire logic axis_adjusted,
   input wire logic signed [POS_W-1:0] setpoint_step,
   input wire logic positioner_module_active,
   input wire logic signed [POS_W-1:0] position_offset_input,
   input wire logic signed [POS_W-1:0] modulo_offset_value,
   input wire logic offset_apply_strobe
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);

   a_ack_follows_req: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_has_cause: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_active_needs_pc: assert property (
      positioner_module_active |-> $past(position_control_active))
      else $error("module active without position control");
   a_strobe_has_value: assert property (
      offset_apply_strobe |-> modulo_offset_value != '0)
      else $error("offset strobe with zero offset");
   a_strobe_when_active: assert property (
      offset_apply_strobe |-> $past(positioner_module_active))
      else $error("offset strobe while module idle");
   a_corr_needs_home: assert property (
      $past(!axis_referenced && !axis_adjusted)
      |-> position_offset_input == '0)
      else $error("correction before homing or adjustment");
   a_corr_still_keep: assert property (
      (setpoint_step == '0 && positioner_module_active
       && axis_referenced && axis_adjusted) [*2]
      |=> $stable(position_offset_input))
      else $error("correction changed at standstill");
endmodule // bmp_checker

bind bmp_positioner bmp_checker u_chk (
   .clock(clock),
   .rst(rst),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .position_control_active(position_control_active),
   .axis_referenced(axis_referenced),
   .axis_adjusted(axis_adjusted),
   .setpoint_step(setpoint_step),
   .positioner_module_active(positioner_module_active),
   .position_offset_input(position_offset_input),
   .modulo_offset_value(modulo_offset_value),
   .offset_apply_strobe(offset_apply_strobe)
);

/* verification/bmp_ctrl_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Position controller and actual-value conditioning stand-in.
module bmp_ctrl_model
   import bmp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic pc_en,
   input wire logic signed [POS_W-1:0] position_setpoint,
   input wire logic signed [POS_W-1:0] position_offset_input,
   input wire logic signed [POS_W-1:0] modulo_offset_value,
   input wire logic offset_apply_strobe,
   output logic position_control_active,
   output logic signed [POS_W-1:0] actual_pos,
   output logic [31:0] apply_count,
   output logic signed [POS_W-1:0] offset_sum
);
   logic strobe_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         position_control_active <= 1'b0;
      end else begin
         position_control_active <= pc_en;
      end
   end

   // Only a rising edge applies the offset; a held strobe counts once.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strobe_q <= 1'b0;
         apply_count <= 32'h0;
         offset_sum <= '0;
      end else begin
         strobe_q <= offset_apply_strobe;
         if (offset_apply_strobe && !strobe_q) begin
            apply_count <= apply_count + 32'h1;
            offset_sum <= offset_sum + modulo_offset_value;
         end
      end
   end

   assign actual_pos = position_setpoint + position_offset_input;
endmodule // bmp_ctrl_model

/* verification/tb.sv */
`timescale 1ns/10ps
module tb
   import bmp_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic pc_en = 1'b0;
   logic axis_referenced = 1'b0;
   logic axis_adjusted = 1'b0;
   logic signed [POS_W-1:0] setpoint_step = '0;
   logic position_control_active;
   logic positioner_module_active;
   logic offset_apply_strobe;
   logic signed [POS_W-1:0] position_setpoint;
   logic signed [POS_W-1:0] position_offset_input;
   logic signed [POS_W-1:0] modulo_offset_value;
   logic [31:0] apply_count;
   logic signed [POS_W-1:0] offset_sum;
   int n_mismatch = 0;
   int check_count = 0;

   always #2.5 clock = ~clock;

   bmp_positioner uut (
      .clock(clock), .rst(rst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .position_control_active(position_control_active),
      .axis_referenced(axis_referenced), .axis_adjusted(axis_adjusted),
      .setpoint_step(setpoint_step),
      .positioner_module_active(positioner_module_active),
      .position_setpoint(position_setpoint),
      .position_offset_input(position_offset_input),
      .modulo_offset_value(modulo_offset_value),
      .offset_apply_strobe(offset_apply_strobe)
   );

   bmp_ctrl_model u_ctrl (
      .clock(clock), .rst(rst), .pc_en(pc_en),
      .position_setpoint(position_setpoint),
      .position_offset_input(position_offset_input),
      .modulo_offset_value(modulo_offset_value),
      .offset_apply_strobe(offset_apply_strobe),
      .position_control_active(position_control_active),
      .actual_pos(), .apply_count(apply_count),
      .offset_sum(offset_sum)
   );

   // ==========================================================
   // Bus and stimulus tasks. All start just after a rising edge.
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic we, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      @(posedge clock);
      while (wb_ack_o !== 1'b1 && n < 50) begin
         @(posedge clock);
         n++;
      end
      if (wb_ack_o !== 1'b1) n_mismatch++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string nm, input logic [5:0] a,
                        input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask

   // Holds a step for n edges, then lets the axis settle at standstill.
   task automatic move(input logic signed [31:0] s, input int n);
      setpoint_step <= s;
      repeat (n) @(posedge clock);
      setpoint_step <= '0;
      repeat (3) @(posedge clock);
   endtask

   task automatic rev(input logic signed [31:0] s, input logic [31:0] e);
      move(-s, 3);
      move(s, 3);
      chk("corr", position_offset_input, e);
   endtask

   task automatic sp(input logic [31:0] c, s, e);
      wr(REG_CTRL, c);
      wr(REG_SETPOINT, s);
      move(32'sh8, 4);
      chk("setpoint", position_setpoint, e);
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence.
   initial begin
      logic [31:0] c0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rdchk("ctrl", REG_CTRL, CTRL_RESET);
      rdchk("unmapped", 6'h3C, BUS_UNMAPPED);
      wr(REG_CTRL, 32'h1);
      repeat (4) @(posedge clock);
      chk("active", 32'(positioner_module_active), 32'h0);
      pc_en <= 1'b1;
      repeat (4) @(posedge clock);
      chk("active", 32'(positioner_module_active), 32'h1);
      rdchk("status", REG_STATUS, 32'h1);
      $display("test activation done");
      wr(REG_BACKLASH, 32'h10);
      rev(-32'sh1, 32'h0);
      axis_referenced <= 1'b1;
      for (int d = 0; d < 2; d++) begin
         wr(REG_CTRL, 32'h1 | (32'(d) << CTRL_HOME_DIR));
         rev(d ? 32'sh1 : -32'sh1, 32'h10);
         rdchk("corr_reg", REG_CORR, 32'h10);
         repeat (4) @(posedge clock);
         chk("corr_keep", position_offset_input, 32'h10);
         rev(d ? -32'sh1 : 32'sh1, 32'h0);
      end
      wr(REG_CTRL, 32'h5);
      rev(-32'sh1, 32'h0);
      axis_adjusted <= 1'b1;
      move(32'sh1, 3);
      chk("corr_none", position_offset_input, 32'h0);
      rev(-32'sh1, 32'h10);
      $display("test backlash done");
      wr(REG_SW_LIM_NEG, 32'h0);
      wr(REG_SW_LIM_POS, 32'h50);
      wr(REG_MOD_RANGE, 32'h100);
      sp(32'h11, 32'h40, 32'h50);
      sp(32'h13, 32'h40, 32'h60);
      c0 = apply_count;
      sp(32'h3, 32'hF0, 32'h10);
      chk("applies", apply_count, c0 + 32'h1);
      chk("offs", modulo_offset_value, 32'hFFFFFF00);
      chk("offs_sum", offset_sum, 32'hFFFFFF00);
      sp(32'h1, 32'hF0, 32'h110);
      chk("applies", apply_count, c0 + 32'h1);
      $display("test modulo done");
      wr(REG_BLK_SEL, 32'h3);
      wr(REG_BLK_HDR, 32'h0A0B1C07);
      wr(REG_BLK_TGT, 32'h1234);
      wr(REG_BLK_PAR, 32'h0000_0055);
      rdchk("blk_par", REG_BLK_PAR, 32'h0000_0055);
      rdchk("blk_hdr", REG_BLK_HDR, 32'h0A0B1C07);
      rdchk("blk_tgt", REG_BLK_TGT, 32'h1234);
      $display("test blocks done");
      stop_test();
   end

   // The full sequence needs well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end
endmodule // tb
